// [core/bkmc_top.sv]
// Purpose: breakpoint compare qualification and mask control
// Assumes: core bus signals on ref_clk, no synchronisers needed
// Notes:   hits are registered, one cycle after the access
// Contract
// [RL1] trace mode forces first-address mask to zero
// [RL2] trace full mode still masks data compare
// [RL3] first-address mask field at bits 7:6
// [RL4] paged full compare uses 20 bits
// [RL5] unpaged full compare uses 16 bits
// [RL6] first mask 1:0 compares all lines
// [RL7] first mask 1:1 matches page only
// [RL8] dual mode second mask at bits 5:4
// [RL9] second mask 1:0 compares all lines
// [RL10] second mask 1:1 matches page only
// [RL11] full mode second mask masks data
// [RL12] bit 3 enables comparator A direction
// [RL13] bit 2: 0 write, 1 read
// [RL14] 0:1 skips low, 1:1 extended only
// [RL15] data mask per byte, no extended
// [RL16] mask register read/write, effective next compare
`timescale 1ns/1ps
`default_nettype none
module bkmc_top (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [7:0]                       reg_rdata,
  input  wire logic                        cpu_valid,
  input  wire logic                        cpu_rw,
  input  wire logic [15:0]                 cpu_addr,
  input  wire logic [15:0]                 cpu_data,
  input  wire logic                        page_sel,
  input  wire logic [bkmc_pkg::PAGE_W-1:0] program_page_index,
  output logic                             comp_a_hit,
  output logic                             comp_b_hit,
  output logic                             break_request
);
  import bkmc_pkg::*;

  logic [7:0] breakpoint_mask_control_reg;
  logic [7:0] comp_a_extended_reg;
  logic [7:0] comp_a_high_reg;
  logic [7:0] comp_a_low_reg;
  logic [7:0] comp_b_extended_reg;
  logic [7:0] comp_b_high_reg;
  logic [7:0] comp_b_low_reg;
  logic [7:0] mode_reg;
  logic [7:0] rdata_reg;
  logic       hit_a_reg;
  logic       hit_b_reg;
  logic       break_reg;

  logic       full_mode;
  logic       trace_capture_mode;
  logic       bk_enable;
  logic       first_addr_high_mask;
  logic       first_addr_low_mask;
  logic       second_addr_high_mask;
  logic       second_addr_low_mask;
  logic       comp_a_direction_enable;
  logic       comp_a_direction_value;
  logic [1:0] a_mask;
  logic [1:0] b_mask;
  logic       a_addr_hit;
  logic       b_addr_hit;
  logic       data_hit;
  logic       dir_ok;
  logic       a_qual;
  logic       b_qual;
  logic [7:0] rdata_next;

  assign full_mode               = mode_reg[MODE_FULL];
  assign trace_capture_mode      = mode_reg[MODE_TRACE];
  assign bk_enable               = mode_reg[MODE_ENABLE];
  assign first_addr_high_mask    = breakpoint_mask_control_reg[FA_MASK_HI]; // RL3
  assign first_addr_low_mask     = breakpoint_mask_control_reg[FA_MASK_LO]; // RL3
  assign second_addr_high_mask   = breakpoint_mask_control_reg[SA_MASK_HI]; // RL8
  assign second_addr_low_mask    = breakpoint_mask_control_reg[SA_MASK_LO]; // RL8
  assign comp_a_direction_enable = breakpoint_mask_control_reg[DIR_EN_BIT]; // RL12
  assign comp_a_direction_value  = breakpoint_mask_control_reg[DIR_VAL_BIT]; // RL13

  // trace capture ignores the first-address mask entirely
  assign a_mask = trace_capture_mode ? MASK_NONE
                : {first_addr_high_mask, first_addr_low_mask}; // RL1
  // same field, read as address mask in dual, data mask in full
  assign b_mask = {second_addr_high_mask, second_addr_low_mask}; // RL2 RL8 RL11

  // direction only counts when enabled; rw high means read
  assign dir_ok = ~comp_a_direction_enable
                | (cpu_rw == comp_a_direction_value); // RL12 RL13

  bkmc_addr_cmp u_cmp_a (
    .ext_val  (comp_a_extended_reg),
    .high_val (comp_a_high_reg),
    .low_val  (comp_a_low_reg),
    .mask     (a_mask),
    .page_sel (page_sel),
    .page_idx (program_page_index),
    .cpu_addr (cpu_addr),
    .hit      (a_addr_hit)
  );

  bkmc_addr_cmp u_cmp_b (
    .ext_val  (comp_b_extended_reg),
    .high_val (comp_b_high_reg),
    .low_val  (comp_b_low_reg),
    .mask     (b_mask),
    .page_sel (page_sel),
    .page_idx (program_page_index),
    .cpu_addr (cpu_addr),
    .hit      (b_addr_hit)
  );

  bkmc_data_cmp u_cmp_d (
    .high_val (comp_b_high_reg),
    .low_val  (comp_b_low_reg),
    .mask     (b_mask),
    .cpu_data (cpu_data),
    .hit      (data_hit)
  );

  assign a_qual = cpu_valid & a_addr_hit & dir_ok;
  // comparator B has no address role in full mode
  assign b_qual = cpu_valid & b_addr_hit & ~full_mode; // RL8

  // mask control register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      breakpoint_mask_control_reg <= MASK_CTRL_RST;
    else if (reg_wr && reg_addr == OFS_MASK_CTRL)
      breakpoint_mask_control_reg <= reg_wdata; // RL16
  end

  // comparator value registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      comp_a_extended_reg <= COMP_RST;
      comp_a_high_reg     <= COMP_RST;
      comp_a_low_reg      <= COMP_RST;
      comp_b_extended_reg <= COMP_RST;
      comp_b_high_reg     <= COMP_RST;
      comp_b_low_reg      <= COMP_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_A_EXT:  comp_a_extended_reg <= reg_wdata;
        OFS_A_HIGH: comp_a_high_reg     <= reg_wdata;
        OFS_A_LOW:  comp_a_low_reg      <= reg_wdata;
        OFS_B_EXT:  comp_b_extended_reg <= reg_wdata;
        OFS_B_HIGH: comp_b_high_reg     <= reg_wdata;
        OFS_B_LOW:  comp_b_low_reg      <= reg_wdata;
        default:    comp_a_low_reg      <= comp_a_low_reg;
      endcase
    end
  end

  // mode register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      mode_reg <= MODE_RST;
    else if (reg_wr && reg_addr == OFS_MODE)
      mode_reg <= reg_wdata;
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    case (reg_addr)
      OFS_MASK_CTRL: rdata_next = breakpoint_mask_control_reg; // RL16
      OFS_A_EXT:     rdata_next = comp_a_extended_reg;
      OFS_A_HIGH:    rdata_next = comp_a_high_reg;
      OFS_A_LOW:     rdata_next = comp_a_low_reg;
      OFS_B_EXT:     rdata_next = comp_b_extended_reg;
      OFS_B_HIGH:    rdata_next = comp_b_high_reg;
      OFS_B_LOW:     rdata_next = comp_b_low_reg;
      OFS_MODE:      rdata_next = mode_reg;
      OFS_STATUS:    rdata_next = {STATUS_PAD, break_reg, hit_b_reg, hit_a_reg};
      default:       rdata_next = RDATA_RST;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_reg <= RDATA_RST;
    else if (reg_rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= RDATA_RST;
  end

  // registered match results
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hit_a_reg <= 1'b0;
      hit_b_reg <= 1'b0;
      break_reg <= 1'b0;
    end
    else
    begin
      hit_a_reg <= a_qual; // RL1 RL4 RL5 RL6 RL7 RL12
      hit_b_reg <= b_qual; // RL9 RL10
      if (full_mode)
        break_reg <= bk_enable & a_qual & data_hit; // RL2 RL11 RL15
      else
        break_reg <= bk_enable & (a_qual | b_qual);
    end
  end

  assign reg_rdata     = rdata_reg;
  assign comp_a_hit    = hit_a_reg;
  assign comp_b_hit    = hit_b_reg;
  assign break_request = break_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  trace_mask_a: assert property ( // RL1
    (cpu_valid && trace_capture_mode && !page_sel
     && comp_a_low_reg != cpu_addr[7:0]) |=> !comp_a_hit)
    else $error("trace mode did not force full first compare");

  trace_data_a: assert property ( // RL2
    (cpu_valid && trace_capture_mode && full_mode && bk_enable && a_qual
     && b_mask == MASK_LOW && comp_b_high_reg == cpu_data[15:8])
    |=> break_request)
    else $error("trace full mode ignored data mask");

  mask_field_a: assert property ( // RL3
    (cpu_valid && !page_sel && !trace_capture_mode
     && breakpoint_mask_control_reg[FA_MASK_HI:FA_MASK_LO] == MASK_BOTH) |=> !comp_a_hit)
    else $error("first mask field not at bits 7:6");

  paged_cmp_a: assert property ( // RL4
    (cpu_valid && page_sel && a_mask == MASK_NONE && !comp_a_direction_enable
     && comp_a_extended_reg[5:0] == program_page_index
     && comp_a_high_reg[5:0] == cpu_addr[13:8]
     && comp_a_low_reg == cpu_addr[7:0]) |=> comp_a_hit)
    else $error("paged 20-bit compare missed");

  unpaged_cmp_a: assert property ( // RL5
    (cpu_valid && !page_sel && comp_a_high_reg != cpu_addr[15:8]
     && a_mask != MASK_BOTH) |=> !comp_a_hit)
    else $error("unpaged compare ignored high byte");

  hi_only_a: assert property ( // RL6
    (cpu_valid && a_mask == MASK_HIGH && !page_sel
     && comp_a_high_reg != cpu_addr[15:8]) |=> !comp_a_hit)
    else $error("mask 1:0 did not compare all lines");

  page_only_a: assert property ( // RL7
    (cpu_valid && a_mask == MASK_BOTH && !page_sel) |=> !comp_a_hit)
    else $error("page-only match without page access");

  dual_b_a: assert property ( // RL8
    (cpu_valid && !full_mode && page_sel && b_mask == MASK_NONE
     && comp_b_extended_reg[5:0] == program_page_index
     && comp_b_high_reg[5:0] == cpu_addr[13:8]
     && comp_b_low_reg == cpu_addr[7:0]) |=> comp_b_hit)
    else $error("second address paged compare missed");

  hi_only_b_a: assert property ( // RL9
    (cpu_valid && b_mask == MASK_HIGH && !page_sel
     && comp_b_high_reg != cpu_addr[15:8]) |=> !comp_b_hit)
    else $error("second mask 1:0 did not compare all lines");

  page_only_b_a: assert property ( // RL10
    (cpu_valid && b_mask == MASK_BOTH && page_sel && !full_mode
     && comp_b_extended_reg[5:0] == program_page_index) |=> comp_b_hit)
    else $error("second page-only match missed");

  full_data_a: assert property ( // RL11
    (full_mode && b_mask == MASK_NONE
     && comp_b_low_reg != cpu_data[7:0]) |=> !break_request && !comp_b_hit)
    else $error("full mode data mismatch broke");

  dir_qual_a: assert property ( // RL12
    (cpu_valid && comp_a_direction_enable
     && cpu_rw != comp_a_direction_value) |=> !comp_a_hit)
    else $error("direction not qualifying comparator A");

  dir_free_a: assert property ( // RL13
    (cpu_valid && a_addr_hit && !comp_a_direction_enable) |=> comp_a_hit)
    else $error("direction value used while disabled");

  range_cmp_a: assert property ( // RL14
    (cpu_valid && a_mask == MASK_LOW && !page_sel && dir_ok
     && comp_a_high_reg == cpu_addr[15:8]) |=> comp_a_hit)
    else $error("256-byte range compare missed");

  no_data_a: assert property ( // RL15
    (full_mode && bk_enable && a_qual && b_mask == MASK_BOTH)
    |=> break_request)
    else $error("data mask 1:1 still compared");

  readback_a: assert property ( // RL16
    (reg_wr && reg_addr == OFS_MASK_CTRL)
    ##1 (reg_rd && reg_addr == OFS_MASK_CTRL)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mask register readback wrong");

  dual_break_c: cover property (!full_mode && bk_enable && b_qual ##1 break_request);
  full_break_c: cover property (full_mode && bk_enable && a_qual ##1 break_request);
  page_hit_c:   cover property (a_mask == MASK_BOTH && a_qual ##1 comp_a_hit);
endmodule
`default_nettype wire

// [core/bkmc_pkg.sv]
// Purpose: shared constants for the breakpoint mask control block
// Assumes: 8-bit register port, registers at printed offsets
// Notes:   mask codes are {high, low} pairs
package bkmc_pkg;
  localparam logic [7:0] OFS_MASK_CTRL = 8'h29;
  localparam logic [7:0] OFS_A_EXT     = 8'h2a;
  localparam logic [7:0] OFS_A_HIGH    = 8'h2b;
  localparam logic [7:0] OFS_A_LOW     = 8'h2c;
  localparam logic [7:0] OFS_B_EXT     = 8'h2d;
  localparam logic [7:0] OFS_B_HIGH    = 8'h2e;
  localparam logic [7:0] OFS_B_LOW     = 8'h2f;
  localparam logic [7:0] OFS_MODE      = 8'h30;
  localparam logic [7:0] OFS_STATUS    = 8'h31;

  localparam int FA_MASK_HI  = 7;
  localparam int FA_MASK_LO  = 6;
  localparam int SA_MASK_HI  = 5;
  localparam int SA_MASK_LO  = 4;
  localparam int DIR_EN_BIT  = 3;
  localparam int DIR_VAL_BIT = 2;

  localparam int MODE_FULL   = 0;
  localparam int MODE_TRACE  = 1;
  localparam int MODE_ENABLE = 2;

  localparam logic [7:0] MASK_CTRL_RST = 8'h00;
  localparam logic [7:0] COMP_RST      = 8'h00;
  localparam logic [7:0] MODE_RST      = 8'h00;
  localparam logic [7:0] RDATA_RST     = 8'h00;
  localparam logic [4:0] STATUS_PAD    = 5'h00;

  localparam int PAGE_W = 6;

  localparam logic [1:0] MASK_NONE   = 2'h0;
  localparam logic [1:0] MASK_LOW    = 2'h1;
  localparam logic [1:0] MASK_HIGH   = 2'h2;
  localparam logic [1:0] MASK_BOTH   = 2'h3;

  // high-only mask on an address is not sensible: fall back to full
  function automatic logic [1:0] bkmc_eff_mask(input logic [1:0] m);
    bkmc_eff_mask = (m == MASK_HIGH) ? MASK_NONE : m;
  endfunction
endpackage

// [core/bkmc_addr_cmp.sv]
// Purpose: one address comparator with byte masking and paging
// Assumes: page_sel high on program page accesses
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module bkmc_addr_cmp (
  input  wire logic [7:0]                  ext_val,
  input  wire logic [7:0]                  high_val,
  input  wire logic [7:0]                  low_val,
  input  wire logic [1:0]                  mask,
  input  wire logic                        page_sel,
  input  wire logic [bkmc_pkg::PAGE_W-1:0] page_idx,
  input  wire logic [15:0]                 cpu_addr,
  output logic                             hit
);
  import bkmc_pkg::*;
  logic [1:0] m;
  logic       ext_ok;
  logic       high_ok;
  logic       low_ok;

  always_comb
  begin
    m       = bkmc_eff_mask(mask); // RL6 RL9
    // paged: 20-bit compare, unpaged: 16-bit compare
    ext_ok  = page_sel ? (ext_val[5:0] == page_idx) : 1'b1; // RL4
    high_ok = page_sel ? (high_val[5:0] == cpu_addr[13:8])
                       : (high_val == cpu_addr[15:8]); // RL5
    low_ok  = (low_val == cpu_addr[7:0]);
    case (m)
      MASK_NONE: hit = ext_ok & high_ok & low_ok;
      MASK_LOW:  hit = ext_ok & high_ok; // RL14
      MASK_BOTH: hit = page_sel & ext_ok; // RL7 RL10 RL14
      default:   hit = ext_ok & high_ok & low_ok;
    endcase
  end
endmodule
`default_nettype wire

// [core/bkmc_data_cmp.sv]
// Purpose: data byte comparator for full mode
// Assumes: 16-bit core data bus
// Notes:   no page compare on data
`timescale 1ns/1ps
`default_nettype none
module bkmc_data_cmp (
  input  wire logic [7:0]  high_val,
  input  wire logic [7:0]  low_val,
  input  wire logic [1:0]  mask,
  input  wire logic [15:0] cpu_data,
  output logic             hit
);
  import bkmc_pkg::*;
  logic hi_ok;
  logic lo_ok;

  always_comb
  begin
    hi_ok = (high_val == cpu_data[15:8]);
    lo_ok = (low_val == cpu_data[7:0]);
    case (mask)
      MASK_NONE: hit = hi_ok & lo_ok; // RL15
      MASK_LOW:  hit = hi_ok; // RL15
      MASK_HIGH: hit = lo_ok; // RL15
      MASK_BOTH: hit = 1'b1; // RL15
      default:   hit = hi_ok & lo_ok;
    endcase
  end
endmodule
`default_nettype wire

// [verification/bkmc_core_model.sv]
// Purpose: processor core bus model facing the breakpoint block
// Assumes: one access per call, then one idle cycle
// Notes:   idle lines carry inverted values so a stale access never matches
`timescale 1ns/1ps
`default_nettype none
module bkmc_core_model (
  input  wire logic        ref_clk,
  output logic             cpu_valid,
  output logic             cpu_rw,
  output logic [15:0]      cpu_addr,
  output logic [15:0]      cpu_data,
  output logic             page_sel,
  output logic [5:0]       program_page_index
);
  initial
  begin
    cpu_valid = 1'b0;
    cpu_rw = 1'b0;
    cpu_addr = 16'h0000;
    cpu_data = 16'h0000;
    page_sel = 1'b0;
    program_page_index = 6'h00;
  end

  // two cycles per access; the idle cycle scrambles every qualifier
  task automatic access(input logic rw, input logic [15:0] a, input logic [15:0] d,
                        input logic ps, input logic [5:0] pg);
    @(posedge ref_clk);
    cpu_valid <= 1'b1;
    cpu_rw <= rw;
    cpu_addr <= a;
    cpu_data <= d;
    page_sel <= ps;
    program_page_index <= pg;
    @(posedge ref_clk);
    cpu_valid <= 1'b0;
    cpu_rw <= ~rw;
    cpu_addr <= ~a;
    cpu_data <= ~d;
    page_sel <= ~ps;
    program_page_index <= ~pg;
  endtask
endmodule
`default_nettype wire

// [verification/bkmc_top_bench.sv]
// Purpose: self-checking bench for the breakpoint mask control block
// Assumes: register port answers one cycle after the read strobe
// Notes:   expected hits come from a private reference of the masks
`timescale 1ns/1ps
`default_nettype none
module bkmc_top_bench;
  import bkmc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        cpu_valid, cpu_rw, page_sel;
  logic [15:0] cpu_addr, cpu_data;
  logic [5:0]  program_page_index;
  logic        comp_a_hit, comp_b_hit, break_request;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [7:0]  exp_rd[$];
  logic [2:0]  exp_hit[$];
  logic        rd_d = 1'b0;
  logic        v_d = 1'b0;
  logic [7:0]  mc, md, ax, ah, al, bx, bh, bl;

  always #12.5 ref_clk = ~ref_clk;

  bkmc_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_valid(cpu_valid),
    .cpu_rw(cpu_rw), .cpu_addr(cpu_addr), .cpu_data(cpu_data), .page_sel(page_sel),
    .program_page_index(program_page_index), .comp_a_hit(comp_a_hit),
    .comp_b_hit(comp_b_hit), .break_request(break_request));

  bkmc_core_model core (.ref_clk(ref_clk), .cpu_valid(cpu_valid), .cpu_rw(cpu_rw),
    .cpu_addr(cpu_addr), .cpu_data(cpu_data), .page_sel(page_sel),
    .program_page_index(program_page_index));

  task automatic end_of_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // high-only mask falls back to a full compare; ext-only needs a paged access
  function automatic logic amatch(input logic [7:0] x, h, l, input logic [1:0] m,
                                  input logic ps, input logic [5:0] pg, input logic [15:0] a);
    logic pe, he, le;
    pe = !ps || (x[5:0] == pg);
    he = ps ? (h[5:0] == a[13:8]) : (h == a[15:8]);
    le = l == a[7:0];
    case (m)
      2'h1:    amatch = pe && he;
      2'h3:    amatch = ps && (x[5:0] == pg);
      default: amatch = pe && he && le;
    endcase
  endfunction

  // bit 1 of the mask hides the high byte, bit 0 the low byte
  function automatic logic dmatch(input logic [1:0] m, input logic [15:0] d);
    dmatch = (m[1] || bh == d[15:8]) && (m[0] || bl == d[7:0]);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // write then read back with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    exp_rd.push_back(d);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic probe;
    logic ps, rw, ua, ub, ud;
    logic [15:0] a, d;
    logic [5:0] pg;
    logic [1:0] f;
    ps = 1'($urandom);
    rw = 1'($urandom);
    f = 2'($urandom);
    a = ($urandom & 1) ? {ah, al} : {bh, bl};
    a[15:14] = ps ? 2'($urandom) : a[15:14];
    pg = ($urandom & 1) ? ax[5:0] : bx[5:0];
    d = {bh, bl} ^ ((($urandom % 3) == 0) ? (16'h0001 << ($urandom % 16)) : 16'h0000);
    case (f)
      2'h1:    a = a ^ (16'h0001 << ($urandom % 8));
      2'h2:    a = a ^ (16'h0100 << ($urandom % 6));
      2'h3:    pg = pg ^ (6'h01 << ($urandom % 6));
      default: ;
    endcase
    ua = amatch(ax, ah, al, md[MODE_TRACE] ? 2'h0 : mc[7:6], ps, pg, a) &&
         (!mc[DIR_EN_BIT] || rw == mc[DIR_VAL_BIT]);
    ub = !md[MODE_FULL] && amatch(bx, bh, bl, mc[5:4], ps, pg, a);
    ud = dmatch(mc[5:4], d);
    exp_hit.push_back({ua, ub, md[MODE_ENABLE] && (md[MODE_FULL] ? ua && ud : ua || ub)});
    core.access(rw, a, d, ps, pg);
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    // outputs are unknown until the first reset edge has passed
    if (!rst)
    begin
      if (rd_d)
        check("reg_rdata", reg_rdata, exp_rd.pop_front());
      else
        check("reg_rdata idle", reg_rdata, 8'h00);
      if (v_d)
        check("hits", {5'h00, comp_a_hit, comp_b_hit, break_request},
              {5'h00, exp_hit.pop_front()});
      else
        check("hits idle", {5'h00, comp_a_hit, comp_b_hit, break_request}, 8'h00);
    end
    rd_d <= reg_rd;
    v_d <= cpu_valid;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  initial
  begin
    void'($urandom(32'h2e2d));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, plus an unmapped place on each side of the map
    for (int i = 8'h28; i <= 8'h32; i++)
      rd(8'(i), 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    // every mask code pair under every mode, other fields random
    for (int k = 0; k < 256; k++)
    begin
      mc = {4'(k), 4'($urandom)};
      md = {5'h00, 3'(k >> 4)};
      ax = 8'($urandom);
      ah = 8'($urandom);
      al = 8'($urandom);
      bx = 8'($urandom);
      bh = 8'($urandom);
      bl = 8'($urandom);
      wr_rd(OFS_MASK_CTRL, mc);
      wr(OFS_MODE, md);
      wr(OFS_A_EXT, ax);
      wr(OFS_A_HIGH, ah);
      wr(OFS_A_LOW, al);
      wr(OFS_B_EXT, bx);
      wr(OFS_B_HIGH, bh);
      wr(OFS_B_LOW, bl);
      repeat (4) probe();
    end
    repeat (4) @(posedge ref_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
